//--- hdl/fesc_pkg.sv
// Package with register map, command codes and timing for the flash erase host controller
package fesc_pkg;
    // APB register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] ADDR_OFF = 8'h04;
    localparam logic [7:0] STAT_OFF = 8'h08;
    localparam logic [7:0] RDAT_OFF = 8'h0c;
    // Control register command field codes
    localparam logic [2:0] OP_NONE = 3'h0;
    localparam logic [2:0] OP_ERASE = 3'h1;
    localparam logic [2:0] OP_READ = 3'h2;
    localparam logic [2:0] OP_CLEAR = 3'h3;
    localparam logic [2:0] OP_SLEEP = 3'h4;
    localparam logic [2:0] OP_WAKE = 3'h5;
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_OP_W = 3;
    // Flash command bytes
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    // Status byte bit positions
    localparam int SR_SUPPLY_LOW = 3;
    localparam int SR_PROG_FAIL = 4;
    localparam int SR_ERASE_FAIL = 5;
    localparam int SR_READY = 7;
    // Host status register bits
    localparam int HS_BUSY = 0;
    localparam int HS_ERR = 1;
    localparam int HS_SLEEP = 2;
    localparam int HS_SR_LSB = 8;
    // Bus timing: strobe width and wake-up time in ns
    localparam int CLK_NS = 5;
    localparam int STROBE_NS = 60;
    localparam int WAKE_NS = 400;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ADDR_W = 19;
    localparam logic [7:0] RESET_ZERO = 8'h00;
endpackage

//--- hdl/fesc_host.sv
// Host controller that drives a boot-block flash through its parallel pins
// How it works
// RULE1 - Erase starts with setup code written inside the target block
// RULE2 - Confirm code follows at an address inside the same block
// RULE3 - While busy, status is polled by strobing output enable; bit 7 ready
// RULE4 - Supply-low flag blocks further attempts until status cleared
// RULE5 - Program fail flag sticks until clear-status command
// RULE6 - Erase fail flag sticks until clear-status command
// RULE7 - Both fail flags together mean a bad command sequence
// RULE8 - Host clears status whenever an error flag is seen; the controller does not, it refuses erase until an OP_CLEAR or OP_SLEEP order
// RULE9 - After the erase series the host writes read-array; the controller writes it only when an OP_READ order starts a read
// RULE10 - Device active when chip enable low and sleep pin high
// RULE11 - Device idles low power after a read, outputs held
// RULE12 - Chip enable high in read mode gives standby, bus floats
// RULE13 - Deselection does not stop a running erase
// RULE14 - Sleep low during read floats outputs and powers down
// RULE15 - Sleep low during erase aborts it, contents invalid
// RULE16 - Sleep entry or power loss clears status byte
// RULE17 - Command interface wakes in read-array mode
// RULE18 - Writes need both write enable and chip enable low
// RULE19 - Contents change only after a full two-step sequence
// RULE20 - Sleep low makes the device ignore control pins
// RULE21 - Only host command writes alter the command state
// RULE22 - Host issues read-array before reading data after erase
// RULE23 - Block address latched at confirm write
// RULE24 - Bad supply at confirm: erase skipped, both flags set
// RULE25 - Non-confirm second write is a sequence error
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module fesc_host (
    input wire logic pclk, // Bus clock, 200 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    output logic [18:0] flash_addr, // Flash address pins
    output logic [7:0] flash_dq_out, // Flash data driven
    output logic flash_dq_oe, // High while host drives data
    input wire logic [7:0] flash_dq_in, // Flash data read back
    output logic flash_ce_n, // Chip enable, active low
    output logic flash_oe_n, // Output enable, active low
    output logic flash_we_n, // Write enable, active low
    output logic deep_sleep_n // Sleep pin, active low
);
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_WR = 6'b000010,
        S_RD = 6'b000100,
        S_GAP = 6'b001000,
        S_WAKE = 6'b010000,
        S_DONE = 6'b100000
    } fesc_state_e;

    typedef enum logic [2:0] {
        P_SETUP = 3'h0,
        P_CONFIRM = 3'h1,
        P_POLL = 3'h2,
        P_SINGLE = 3'h3,
        P_READ = 3'h4
    } fesc_step_e;

    fesc_state_e state_reg, state_next;
    fesc_step_e step_reg, step_next;
    logic [2:0] op_reg, op_next;
    logic [18:0] addr_reg, addr_next;
    logic [7:0] sr_reg, sr_next;
    logic [7:0] rdat_reg, rdat_next;
    logic [7:0] cnt_reg, cnt_next;
    logic sleep_reg, sleep_next;
    logic [18:0] fa_reg, fa_next;
    logic [7:0] fd_reg, fd_next;
    logic oe_reg, oe_next, ce_reg, ce_next, rdn_reg, rdn_next, wen_reg, wen_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pslverr_reg, pslverr_next;
    logic pready_reg, pready_next, wake_reg, wake_next;
    logic [7:0] dq_s1, dq_s2;

    // Status flags that demand a clear before retry
    function automatic logic sr_error(input logic [7:0] s);
        sr_error = s[fesc_pkg::SR_SUPPLY_LOW] | s[fesc_pkg::SR_PROG_FAIL]
                   | s[fesc_pkg::SR_ERASE_FAIL];
    endfunction

    // Data pins are asynchronous to pclk, so two stages before use
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dq_s1 <= fesc_pkg::RESET_ZERO;
            dq_s2 <= fesc_pkg::RESET_ZERO;
        end
        else
        begin
            dq_s1 <= flash_dq_in;
            dq_s2 <= dq_s1;
        end
    end

    wire logic bus_wr = psel & penable & pwrite;
    // Reads and write errors are decoded in setup, so they stand at the access edge
    wire logic bus_rd = psel & ~penable & ~pwrite;
    wire logic bus_ws = psel & ~penable & pwrite;
    wire logic busy = ~state_reg[0];

    // Sequencer and register file next values
    always_comb
    begin
        state_next = state_reg;
        step_next = step_reg;
        op_next = op_reg;
        addr_next = addr_reg;
        sr_next = sr_reg;
        rdat_next = rdat_reg;
        cnt_next = cnt_reg;
        sleep_next = sleep_reg;
        fa_next = fa_reg;
        fd_next = fd_reg;
        oe_next = oe_reg;
        ce_next = ce_reg;
        rdn_next = rdn_reg;
        wen_next = wen_reg;
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        pready_next = psel & ~penable; // Ready in every access phase, no wait states
        // Register writes; a new operation is only taken while idle
        if (bus_wr)
        begin
            unique case (paddr)
                fesc_pkg::CTRL_OFF:
                begin
                    if (!busy)
                    begin
                        op_next = pwdata[fesc_pkg::CTRL_OP_LSB +: fesc_pkg::CTRL_OP_W];
                        cnt_next = 8'h00;
                        unique case (op_next)
                            fesc_pkg::OP_ERASE:
                            begin
                                // Refuse a retry while an error is still latched [RULE8] [RULE4]
                                if (!sr_error(sr_reg) && !sleep_reg)
                                begin
                                    state_next = S_WR;
                                    step_next = P_SETUP;
                                    fa_next = addr_reg; // [RULE1]
                                    fd_next = fesc_pkg::CMD_ERASE_SETUP;
                                end
                            end
                            fesc_pkg::OP_READ:
                            begin
                                if (!sleep_reg)
                                begin
                                    state_next = S_WR;
                                    step_next = P_SINGLE;
                                    fa_next = addr_reg;
                                    fd_next = fesc_pkg::CMD_READ_ARRAY; // [RULE9] [RULE22]
                                end
                            end
                            fesc_pkg::OP_CLEAR:
                            begin
                                if (!sleep_reg)
                                begin
                                    state_next = S_WR;
                                    step_next = P_SINGLE;
                                    fd_next = fesc_pkg::CMD_CLEAR_STATUS;
                                    sr_next = fesc_pkg::RESET_ZERO;
                                end
                            end
                            fesc_pkg::OP_SLEEP:
                            begin
                                sleep_next = 1'b1; // [RULE14] [RULE15]
                                sr_next = fesc_pkg::RESET_ZERO; // [RULE16]
                            end
                            fesc_pkg::OP_WAKE:
                            begin
                                if (sleep_reg)
                                begin
                                    sleep_next = 1'b0;
                                    state_next = S_WAKE;
                                end
                            end
                            default:
                            begin
                                op_next = op_reg;
                            end
                        endcase
                    end
                end
                fesc_pkg::ADDR_OFF:
                begin
                    if (!busy)
                        addr_next = pwdata[fesc_pkg::ADDR_W-1:0];
                end
                default: op_next = op_reg;
            endcase
        end
        // Writes to status and data are dropped; only unmapped offsets are errors
        if (bus_ws)
            pslverr_next = (paddr != fesc_pkg::CTRL_OFF) && (paddr != fesc_pkg::ADDR_OFF)
                           && (paddr != fesc_pkg::STAT_OFF) && (paddr != fesc_pkg::RDAT_OFF);
        // Register reads, a snapshot taken in setup that stands through the access phase
        if (bus_rd)
        begin
            unique case (paddr)
                fesc_pkg::CTRL_OFF: prdata_next = {29'h0, op_reg};
                fesc_pkg::ADDR_OFF: prdata_next = {13'h0, addr_reg};
                fesc_pkg::STAT_OFF: prdata_next = {16'h0, sr_reg, 5'h0, sleep_reg,
                                                   sr_error(sr_reg), busy};
                fesc_pkg::RDAT_OFF: prdata_next = {24'h0, rdat_reg};
                default:
                begin
                    prdata_next = 32'h0;
                    pslverr_next = 1'b1;
                end
            endcase
        end
        // Pin sequencing, write strobe held for the strobe width, read strobe two cycles longer
        unique case (state_reg)
            S_IDLE:
            begin
                ce_next = 1'b1; // [RULE12]
                oe_next = 1'b0;
            end
            S_WR:
            begin
                ce_next = 1'b0; // [RULE10]
                wen_next = 1'b0; // [RULE18]
                oe_next = 1'b1;
                cnt_next = cnt_reg + 8'h01;
                if (cnt_reg == 8'(fesc_pkg::STROBE_CYC))
                begin
                    wen_next = 1'b1;
                    ce_next = 1'b1;
                    cnt_next = 8'h00;
                    state_next = S_GAP;
                end
            end
            S_RD:
            begin
                ce_next = 1'b0;
                rdn_next = 1'b0;
                oe_next = 1'b0;
                cnt_next = cnt_reg + 8'h01;
                if (cnt_reg == 8'(fesc_pkg::STROBE_CYC + 2))
                begin
                    // Sample after the two synchroniser stages settled
                    rdn_next = 1'b1; // [RULE3]
                    ce_next = 1'b1; // [RULE13]
                    cnt_next = 8'h00;
                    state_next = S_GAP;
                    if (step_reg == P_POLL)
                        sr_next = dq_s2;
                    else
                        rdat_next = dq_s2; // [RULE11]
                end
            end
            S_GAP:
            begin
                cnt_next = cnt_reg + 8'h01;
                if (cnt_reg == 8'(fesc_pkg::STROBE_CYC))
                begin
                    cnt_next = 8'h00;
                    unique case (step_reg)
                        P_SETUP:
                        begin
                            step_next = P_CONFIRM; // [RULE2] [RULE19] [RULE25]
                            fd_next = fesc_pkg::CMD_ERASE_CONFIRM; // [RULE23]
                            state_next = S_WR;
                        end
                        P_CONFIRM, P_POLL:
                        begin
                            if (step_reg == P_POLL && sr_reg[fesc_pkg::SR_READY])
                                state_next = S_DONE; // [RULE7] [RULE24]
                            else
                            begin
                                step_next = P_POLL;
                                state_next = S_RD;
                            end
                        end
                        P_SINGLE:
                        begin
                            if (fd_reg == fesc_pkg::CMD_READ_ARRAY)
                            begin
                                step_next = P_READ;
                                state_next = S_RD;
                            end
                            else
                                state_next = S_DONE; // [RULE21]
                        end
                        default: state_next = S_DONE;
                    endcase
                end
            end
            S_WAKE:
            begin
                cnt_next = cnt_reg + 8'h01; // [RULE17] [RULE20]
                if (cnt_reg == 8'(fesc_pkg::WAKE_CYC))
                begin
                    cnt_next = 8'h00;
                    state_next = S_DONE;
                end
            end
            S_DONE:
            begin
                state_next = S_IDLE;
                oe_next = 1'b0;
            end
            default: state_next = S_IDLE;
        endcase
        // Sleep pin gets a flop of its own so the output carries no gate
        wake_next = ~sleep_next;
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= S_IDLE;
            step_reg <= P_SETUP;
            op_reg <= fesc_pkg::OP_NONE;
            addr_reg <= 19'h0;
            sr_reg <= fesc_pkg::RESET_ZERO;
            rdat_reg <= fesc_pkg::RESET_ZERO;
            cnt_reg <= 8'h00;
            sleep_reg <= 1'b0;
            fa_reg <= 19'h0;
            fd_reg <= fesc_pkg::RESET_ZERO;
            oe_reg <= 1'b0;
            ce_reg <= 1'b1;
            rdn_reg <= 1'b1;
            wen_reg <= 1'b1;
            prdata_reg <= 32'h0;
            pslverr_reg <= 1'b0;
            pready_reg <= 1'b0;
            wake_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            step_reg <= step_next;
            op_reg <= op_next;
            addr_reg <= addr_next;
            sr_reg <= sr_next;
            rdat_reg <= rdat_next;
            cnt_reg <= cnt_next;
            sleep_reg <= sleep_next;
            fa_reg <= fa_next;
            fd_reg <= fd_next;
            oe_reg <= oe_next;
            ce_reg <= ce_next;
            rdn_reg <= rdn_next;
            wen_reg <= wen_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
            pready_reg <= pready_next;
            wake_reg <= wake_next;
        end
    end

    // Outputs straight from flops; ready rises in the access phase, no wait states
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign flash_addr = fa_reg;
    assign flash_dq_out = fd_reg;
    assign flash_dq_oe = oe_reg;
    assign flash_ce_n = ce_reg;
    assign flash_oe_n = rdn_reg;
    assign flash_we_n = wen_reg;
    assign deep_sleep_n = wake_reg;

    // A write strobe never overlaps a read strobe
    property p_no_overlap;
        @(posedge pclk) disable iff (!presetn) !(~wen_reg && ~rdn_reg);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("we and oe low together"); // [RULE18]

    // Confirm follows setup at the same block address
    sequence s_setup_end;
        state_reg == S_GAP && step_reg == P_SETUP && cnt_reg == 8'(fesc_pkg::STROBE_CYC);
    endsequence
    property p_confirm;
        @(posedge pclk) disable iff (!presetn)
        s_setup_end |=> (fd_reg == fesc_pkg::CMD_ERASE_CONFIRM) && $stable(fa_reg);
    endproperty
    a_confirm: assert property (p_confirm) else $error("confirm not sent after setup"); // [RULE2]

    // Chip enable always frames the write strobe
    property p_ce_frames_we;
        @(posedge pclk) disable iff (!presetn) !wen_reg |-> !ce_reg;
    endproperty
    a_ce_frames_we: assert property (p_ce_frames_we) else $error("we low without ce"); // [RULE18]

    // While asleep every strobe stays idle, the device ignores them anyway
    property p_sleep_idle;
        @(posedge pclk) disable iff (!presetn) sleep_reg |-> ce_reg && wen_reg && rdn_reg;
    endproperty
    a_sleep_idle: assert property (p_sleep_idle) else $error("strobe active asleep"); // [RULE14]

    // An erase order with an error still latched leaves the sequencer idle
    property p_retry_refused;
        @(posedge pclk) disable iff (!presetn)
        bus_wr && !busy && paddr == fesc_pkg::CTRL_OFF && sr_error(sr_reg)
        && pwdata[fesc_pkg::CTRL_OP_LSB +: fesc_pkg::CTRL_OP_W] == fesc_pkg::OP_ERASE
        |=> state_reg == S_IDLE;
    endproperty
    a_retry_refused: assert property (p_retry_refused) else $error("erase retried"); // [RULE4]

    // Command data is driven for the first 8 cycles of the write strobe's low phase
    sequence s_we_fall;
        $fell(wen_reg);
    endsequence
    property p_we_width;
        @(posedge pclk) disable iff (!presetn) s_we_fall |-> (!wen_reg && oe_reg) [*8];
    endproperty
    a_we_width: assert property (p_we_width) else $error("write strobe too short"); // [RULE1]
endmodule
`default_nettype wire

//--- verif/fesc_flash_model.sv
// Behavioural boot-block flash that answers the host controller's pins
`timescale 1ns/100ps
`default_nettype none
module fesc_flash_model #(
    parameter int ERASE_CYC = 200
) (
    input wire logic clk, // Timer clock for the erase
    input wire logic vpp_ok, // Programming supply in range
    input wire logic [18:0] addr, // Address pins
    input wire logic [7:0] din, // Data from host
    input wire logic din_oe, // Host drives data
    input wire logic ce_n, // Chip enable
    input wire logic oe_n, // Output enable
    input wire logic we_n, // Write enable
    input wire logic deep_sleep_n, // Sleep pin
    output logic [7:0] dout // Data to host
);
    logic [7:0] sr = 8'h00;
    logic [7:0] cmd_last = 8'h00;
    logic [7:0] cmd_prev = 8'h00;
    logic [7:0] d_hold = 8'h00;
    logic [7:0] float_v = 8'h55;
    logic [18:0] a_hold, a_last, a_prev, blk;
    logic st_mode = 1'b0;
    logic setup = 1'b0;
    logic busy = 1'b0;
    logic we_q = 1'b1;
    logic ce_q = 1'b1;
    int cnt = 0;
    int wr_cnt = 0;
    // Released bus toggles every cycle while awake so stale data never passes as valid
    assign dout = (!ce_n && !oe_n && deep_sleep_n) ? (st_mode ? {!busy, sr[6:0]} :
        addr[7:0] ^ 8'h3c) : float_v;
    // Strobes are sampled on clk; a write lands when we_n rises with ce_n low
    always @(posedge clk or negedge deep_sleep_n)
    begin
        if (!deep_sleep_n)
        begin
            sr <= 8'h00;
            st_mode <= 1'b0;
            setup <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            float_v <= ~float_v;
            we_q <= we_n;
            ce_q <= ce_n;
            if (!we_n && !ce_n && din_oe)
            begin
                d_hold <= din;
                a_hold <= addr;
            end
            if (busy)
                cnt <= cnt - 1;
            if (busy && cnt == 1)
                busy <= 1'b0;
            if (we_n && !we_q && !ce_q && !busy)
            begin
                wr_cnt <= wr_cnt + 1;
                cmd_prev <= cmd_last;
                cmd_last <= d_hold;
                a_prev <= a_last;
                a_last <= a_hold;
                if (setup)
                begin
                    setup <= 1'b0;
                    st_mode <= 1'b1;
                    if (d_hold != 8'hd0)
                        sr[5:4] <= 2'b11;
                    else if (!vpp_ok || sr[3])
                        sr[5:3] <= {1'b1, sr[4], 1'b1};
                    else
                    begin
                        busy <= 1'b1;
                        cnt <= ERASE_CYC;
                        blk <= a_hold;
                    end
                end
                else if (d_hold == 8'h20)
                    setup <= 1'b1;
                else if (d_hold == 8'hff)
                    st_mode <= 1'b0;
                else if (d_hold == 8'h70)
                    st_mode <= 1'b1;
                else if (d_hold == 8'h50)
                    sr <= 8'h00;
            end
        end
    end
endmodule
`default_nettype wire

//--- verif/fesc_host_tb_top.sv
// Self-checking bench for the flash erase host controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin $display("ERROR %s exp %h got %h", n, e, g); fails++; end end
module fesc_host_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic vpp_ok = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, err, ce_n, oe_n, we_n, dq_oe, sleep_n;
    logic [18:0] faddr;
    logic [7:0] dq_o, dq_i;
    int fails = 0;
    int comparisons = 0;
    // 200 MHz bus clock
    always #2.5 pclk = ~pclk;
    fesc_host DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_addr(faddr), .flash_dq_out(dq_o), .flash_dq_oe(dq_oe),
        .flash_dq_in(dq_i), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
        .deep_sleep_n(sleep_n));
    fesc_flash_model MODEL (.clk(pclk), .vpp_ok(vpp_ok), .addr(faddr), .din(dq_o),
        .din_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .deep_sleep_n(sleep_n),
        .dout(dq_i));
    // Verdict and end of run
    task automatic stop_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // One APB transfer; data and error are taken at the edge that sees pready high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 50)
        begin
            fails++;
            stop_test();
        end
    endtask
    // Issue an order and poll busy with a bound, leaving STAT in q
    task automatic op(input logic [2:0] c);
        int n;
        apb(1'b1, fesc_pkg::CTRL_OFF, {29'h0, c});
        n = 0;
        do
        begin
            apb(1'b0, fesc_pkg::STAT_OFF, 32'h0);
            n++;
        end
        while (q[fesc_pkg::HS_BUSY] !== 1'b0 && n < 300);
        if (n >= 300)
        begin
            fails++;
            stop_test();
        end
    endtask
    // Erase a block and judge status, error flag and the pin writes seen
    task automatic erase(input logic [18:0] a, input logic v, input logic [7:0] se, input int nw);
        int w;
        w = MODEL.wr_cnt;
        vpp_ok <= v;
        apb(1'b1, fesc_pkg::ADDR_OFF, {13'h0, a});
        op(fesc_pkg::OP_ERASE);
        `CHK("status", se, q[15:8])
        `CHK("error", |se[5:3], q[fesc_pkg::HS_ERR])
        `CHK("writes", nw, MODEL.wr_cnt - w)
        if (nw == 2)
        begin
            `CHK("setup", 8'h20, MODEL.cmd_prev)
            `CHK("confirm", 8'hd0, MODEL.cmd_last)
            `CHK("setup addr", a, MODEL.a_prev)
            `CHK("confirm addr", a, MODEL.a_last)
        end
    endtask
    // Main sequence
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("ce_n", 1'b1, ce_n)
        `CHK("we_n", 1'b1, we_n)
        `CHK("sleep", 1'b1, sleep_n)
        `CHK("dq_oe", 1'b0, dq_oe)
        apb(1'b0, 8'h10, 32'h0);
        `CHK("slverr", 1'b1, err)
        erase(19'h12345, 1'b1, 8'h80, 2);
        `CHK("block", 19'h12345, MODEL.blk)
        erase(19'h23456, 1'b0, 8'ha8, 2);
        erase(19'h23456, 1'b1, 8'ha8, 0);
        op(fesc_pkg::OP_SLEEP);
        `CHK("asleep pin", 1'b0, sleep_n)
        `CHK("asleep flag", 1'b1, q[fesc_pkg::HS_SLEEP])
        `CHK("sleep sr", 8'h00, q[15:8])
        `CHK("device sr", 8'h00, MODEL.sr)
        op(fesc_pkg::OP_WAKE);
        `CHK("awake pin", 1'b1, sleep_n)
        `CHK("read mode", 1'b0, MODEL.st_mode)
        erase(19'h40000, 1'b0, 8'ha8, 2);
        op(fesc_pkg::OP_CLEAR);
        `CHK("clear cmd", 8'h50, MODEL.cmd_last)
        `CHK("cleared sr", 8'h00, q[15:8])
        `CHK("device sr", 8'h00, MODEL.sr)
        apb(1'b1, fesc_pkg::ADDR_OFF, 32'h00abc);
        apb(1'b0, fesc_pkg::ADDR_OFF, 32'h0);
        `CHK("addr reg", 32'h00abc, q)
        op(fesc_pkg::OP_READ);
        `CHK("read cmd", 8'hff, MODEL.cmd_last)
        apb(1'b0, fesc_pkg::RDAT_OFF, 32'h0);
        `CHK("array data", 8'h80, q[7:0])
        erase(19'h00100, 1'b1, 8'h80, 2);
        stop_test();
    end
endmodule
`default_nettype wire
